// ==== core/mmrd_decoder.sv ====
`timescale 1ns/10ps
`include "mmrd_regs.svh"

// What this block does
// - After reset flash is aliased at address zero.
// - Clearing bit 0 of the swap register puts SRAM at address zero.
// - Multi-byte values are stored little-endian.
// - A 32-bit flash access takes two consecutive 16-bit flash reads.
// - Flash is 32k halfwords, the top 1k reserved for the boot loader.
// - Flash is split into 256-byte pages.
// - An 8 kB SRAM and a 64 kB flash sit in one linear address space.
// - A fast interrupt wins over a normal one when both are pending.
// - The shortest interrupt path to exception entry is five cycles.
// - A fast interrupt reaches its vector within 41 cycles.
// - Flash fetch runs full rate for halfwords, half rate for words.
// - The core clock is the 45 MHz clock through a programmable divider.
// - SRAM is 2k words of 32 bits, single-cycle word access.
// - Peripheral registers decode in the two 256-byte pages from 0xFFFF0000.
module mmrd_decoder
    import mmrd_pkg::*;
#(
    parameter int SRAM_WORDS = 2048,
    parameter int FLASH_HW   = 32768
) (
    input  wire logic              clk_i,        // 45 MHz source clock
    input  wire logic              rstn_i,       // Async reset, active low
    input  wire mmrd_req_t         req_i,        // Processor request
    input  wire logic              remap_wr_i,   // Write strobe for swap register
    input  wire logic [7:0]        remap_wdata_i,// Swap register write data
    input  wire logic [`MMRD_DIV_W-1:0] cdiv_i,  // Core clock divide (2^n)
    input  wire logic [15:0]       flash_rdata_i,// Flash halfword read data
    input  wire logic              fiq_i,        // Fast interrupt request
    input  wire logic              irq_i,        // Normal interrupt request
    output mmrd_rsp_t              rsp_o,        // Answer to processor
    output logic                   remap_o,      // Swap register bit 0
    output logic                   flash_re_o,   // Flash read strobe
    output logic [14:0]            flash_addr_o, // Flash halfword address
    output logic [7:0]             flash_page_o, // Page of flash access
    output logic                   flash_boot_o, // Access hits boot area
    output logic                   mmr_sel_o,    // Peripheral space selected
    output logic                   core_clk_en_o,// Core clock enable pulse
    output logic                   fiq_take_o,   // Enter fast interrupt
    output logic                   irq_take_o,   // Enter normal interrupt
    output logic [31:0]            vector_o      // Exception vector
);

    // Memory sizes are fixed by the address map; refuse anything else
    if (SRAM_WORDS != 2048 || FLASH_HW != 32768) begin : g_size_check
        $error("mmrd_decoder: memory sizes are fixed by the map");
    end

    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    logic [31:0] sram_mem [SRAM_WORDS];
    mmrd_state_t state_reg;
    logic        remap_reg;
    logic [15:0] lo_half_reg;
    logic [31:0] cur_addr_reg;
    logic [`MMRD_DIV_W-1:0] div_cnt_reg;
    logic [2:0]  fiq_sync_reg;
    logic [2:0]  irq_sync_reg;
    logic [2:0]  entry_cnt_reg;

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------
    logic low_hit, sram_hit, flash_hit, mmr_hit;
    always_comb begin
        // Low window follows the swap bit
        low_hit   = req_i.addr < `MMRD_LOW_BYTES;
        sram_hit  = (req_i.addr >= `MMRD_SRAM_BASE &&
                     req_i.addr <  `MMRD_SRAM_BASE + `MMRD_SRAM_BYTES) ||
                    (low_hit && !remap_reg && req_i.addr < `MMRD_SRAM_BYTES);
        flash_hit = (req_i.addr >= `MMRD_FLASH_BASE &&
                     req_i.addr <  `MMRD_FLASH_BASE + `MMRD_FLASH_BYTES) ||
                    (low_hit && remap_reg);
        mmr_hit   = req_i.addr >= `MMRD_MMR_BASE &&
                    req_i.addr <  `MMRD_MMR_BASE + `MMRD_MMR_BYTES;
    end

    logic [10:0] sram_idx;
    assign sram_idx = req_i.addr[12:2];

    // A request is taken only while no answer is out, so a master that holds
    // valid up to the edge that sees ready is not served twice
    logic req_take;
    assign req_take = req_i.valid && !rsp_o.ready;

    //--------------------------------------------------------------
    // Swap register; set after every reset so flash is at zero
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            remap_reg <= `MMRD_REMAP_RST;
        end else if (remap_wr_i) begin
            remap_reg <= remap_wdata_i[`MMRD_REMAP_BIT];
        end
    end
    assign remap_o = remap_reg;

    //--------------------------------------------------------------
    // SRAM with byte lanes, little-endian
    //--------------------------------------------------------------
    logic [3:0] lane;
    always_comb begin
        unique case (req_i.size)
            2'h0:    lane = 4'h1 << req_i.addr[1:0];
            2'h1:    lane = req_i.addr[1] ? 4'hC : 4'h3;
            default: lane = 4'hF;
        endcase
    end
    // Byte n of the word lives at address offset n
    always_ff @(posedge clk_i) begin
        if (state_reg == MMRD_IDLE && req_take && req_i.write && sram_hit) begin
            for (int b = 0; b < 4; b++)
                if (lane[b]) sram_mem[sram_idx][b*8 +: 8] <= req_i.wdata[b*8 +: 8];
        end
    end

    //--------------------------------------------------------------
    // Access sequencer; flash is read-only here
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg    <= MMRD_IDLE;
            rsp_o        <= '0;
            flash_re_o   <= 1'b0;
            flash_addr_o <= '0;
            flash_page_o <= '0;
            flash_boot_o <= 1'b0;
            mmr_sel_o    <= 1'b0;
            lo_half_reg  <= '0;
            cur_addr_reg <= '0;
        end else begin
            rsp_o.ready <= 1'b0;
            rsp_o.error <= 1'b0;
            flash_re_o  <= 1'b0;
            mmr_sel_o   <= 1'b0;
            unique case (state_reg)
                MMRD_IDLE: if (req_take) begin
                    cur_addr_reg <= req_i.addr;
                    if (sram_hit) begin
                        // One-cycle word access
                        rsp_o.ready <= 1'b1;
                        rsp_o.rdata <= sram_mem[sram_idx];
                    end else if (flash_hit && !req_i.write) begin
                        flash_re_o   <= 1'b1;
                        flash_addr_o <= req_i.addr[15:1];
                        flash_page_o <= req_i.addr[15:8];
                        flash_boot_o <= req_i.addr[15:1] >= `MMRD_BOOT_HW_FIRST;
                        // Words need a second halfword
                        state_reg    <= (req_i.size == 2'h2) ? MMRD_FLO : MMRD_DONE;
                    end else if (mmr_hit) begin
                        mmr_sel_o   <= 1'b1;
                        rsp_o.ready <= 1'b1;
                        rsp_o.rdata <= '0;
                    end else begin
                        rsp_o.ready <= 1'b1;
                        rsp_o.error <= 1'b1;
                    end
                end
                MMRD_FLO: begin
                    lo_half_reg  <= flash_rdata_i;
                    flash_re_o   <= 1'b1;
                    flash_addr_o <= flash_addr_o + 15'h1;
                    state_reg    <= MMRD_FHI;  // Processor held waiting
                end
                MMRD_FHI: begin
                    rsp_o.ready <= 1'b1;
                    rsp_o.rdata <= {flash_rdata_i, lo_half_reg};
                    state_reg   <= MMRD_IDLE;
                end
                MMRD_DONE: begin
                    rsp_o.ready <= 1'b1;
                    rsp_o.rdata <= {flash_rdata_i, flash_rdata_i};  // Half in both lanes
                    state_reg   <= MMRD_IDLE;
                end
                default: state_reg <= MMRD_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Core clock divider, divide by 2^cdiv, capped at 8 for cdiv above 3
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_reg   <= '0;
            core_clk_en_o <= 1'b0;
        end else begin
            div_cnt_reg   <= div_cnt_reg + 1'b1;
            // Enable pulse at source/2^n rate, n capped at 3
            core_clk_en_o <= ((div_cnt_reg & ((`MMRD_DIV_W'(1) << cdiv_i) - 1'b1)) == '0);
        end
    end

    //--------------------------------------------------------------
    // Interrupt synchronisers and entry; fast wins over normal
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fiq_sync_reg  <= '0;
            irq_sync_reg  <= '0;
            entry_cnt_reg <= '0;
            fiq_take_o    <= 1'b0;
            irq_take_o    <= 1'b0;
            vector_o      <= '0;
        end else begin
            fiq_sync_reg <= {fiq_sync_reg[1:0], fiq_i};
            irq_sync_reg <= {irq_sync_reg[1:0], irq_i};
            fiq_take_o   <= 1'b0;
            irq_take_o   <= 1'b0;
            if (entry_cnt_reg != '0) begin
                entry_cnt_reg <= entry_cnt_reg - 1'b1;
                if (entry_cnt_reg == 3'h1) begin
                    if (fiq_sync_reg[2]) begin
                        fiq_take_o <= 1'b1;
                        vector_o   <= `MMRD_FIQ_VECTOR;
                    end else if (irq_sync_reg[2]) begin
                        irq_take_o <= 1'b1;
                        vector_o   <= `MMRD_IRQ_VECTOR;
                    end
                end
            end else if (fiq_sync_reg[2] || irq_sync_reg[2]) begin
                // Loading edge is the first of two entry cycles: 3 + 2 = five
                entry_cnt_reg <= `MMRD_IRQ_ENTRY_CYC - 3'h1;
            end
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    fiq_prio_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(fiq_take_o && irq_take_o)) else $error("both interrupts taken");
    fiq_latency_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(fiq_i) && entry_cnt_reg == '0 ##1 fiq_i[*4] |=> fiq_take_o)
        else $error("fast interrupt not entered in five cycles");
    flash_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == MMRD_FLO |=> flash_re_o && !rsp_o.ready ##1 rsp_o.ready)
        else $error("word flash read not two halfwords");
    flash_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == MMRD_FLO |=> flash_addr_o == $past(flash_addr_o) + 15'h1)
        else $error("second halfword address wrong");
    word_order_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == MMRD_FHI |=> rsp_o.rdata[15:0] == $past(lo_half_reg))
        else $error("low halfword misplaced");
    remap_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        remap_wr_i && !remap_wdata_i[0] |=> !remap_o)
        else $error("swap bit not cleared");
    zero_flash_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        remap_o && state_reg == MMRD_IDLE && req_take && !req_i.write
        && req_i.addr == 32'h0 |=> flash_re_o && flash_addr_o == 15'h0)
        else $error("address zero not flash");
    mmr_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == MMRD_IDLE && req_take && req_i.addr[31:16] == 16'hFFFF
        && req_i.addr[15:9] == 7'h0 |=> mmr_sel_o)
        else $error("peripheral page not decoded");

endmodule // mmrd_decoder

// ==== shared/mmrd_pkg.sv ====
package mmrd_pkg;
    // Processor request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;   // 0 byte, 1 half, 2 word
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmrd_req_t;
    // Answer to processor
    typedef struct packed {
        logic        ready;
        logic        error;
        logic [31:0] rdata;
    } mmrd_rsp_t;
    typedef enum logic [3:0] {
        MMRD_IDLE  = 4'b0001,
        MMRD_FLO   = 4'b0010,
        MMRD_FHI   = 4'b0100,
        MMRD_DONE  = 4'b1000
    } mmrd_state_t;
endpackage

// ==== shared/mmrd_regs.svh ====
`ifndef MMRD_REGS_SVH
`define MMRD_REGS_SVH
// Address map
`define MMRD_FLASH_BASE     32'h0008_0000
`define MMRD_SRAM_BASE      32'h0001_0000
`define MMRD_MMR_BASE       32'hFFFF_0000
`define MMRD_FLASH_BYTES    32'h0001_0000
`define MMRD_SRAM_BYTES     32'h0000_2000
`define MMRD_MMR_BYTES      32'h0000_0200
`define MMRD_LOW_BYTES      32'h0001_0000
`define MMRD_PAGE_BYTES     9'h100
`define MMRD_BOOT_HW_FIRST  15'h7C00
`define MMRD_REMAP_BIT      0
`define MMRD_REMAP_RST      1'b1
// Interrupt timing in source clock cycles
`define MMRD_IRQ_SYNC_CYC   3'h3
`define MMRD_IRQ_ENTRY_CYC  3'h2
`define MMRD_FIQ_WORST_CYC  6'h29
`define MMRD_FIQ_VECTOR     32'h0000_001C
`define MMRD_IRQ_VECTOR     32'h0000_0018
// Clock
`define MMRD_SRC_MHZ        45
`define MMRD_DIV_W          3
`endif

// ==== sim/memory_map_remap_decoder_tb.sv ====
`timescale 1ns/10ps
`include "mmrd_regs.svh"
module memory_map_remap_decoder_tb;
    import mmrd_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk, rstn, remap_wr, fiq, irq, er, boot, mmr;
    logic        remap, fre, fboot, msel, cen, ftake, itake;
    logic [2:0]  cdiv;
    logic [7:0]  remap_wd, pg, fpage;
    logic [14:0] faddr;
    logic [15:0] frd;
    logic [31:0] rd, w, a, vec;
    logic [15:0] ofs [3] = '{16'hF7FE, 16'hF800, 16'h0100};
    mmrd_req_t   req;
    mmrd_rsp_t   rsp;
    int          errors, num_checks, cyc, lat, nre, i, k, seed;

    mmrd_decoder dut (.clk_i(clk), .rstn_i(rstn), .req_i(req), .remap_wr_i(remap_wr),
        .remap_wdata_i(remap_wd), .cdiv_i(cdiv), .flash_rdata_i(frd), .fiq_i(fiq),
        .irq_i(irq), .rsp_o(rsp), .remap_o(remap), .flash_re_o(fre), .flash_addr_o(faddr),
        .flash_page_o(fpage), .flash_boot_o(fboot), .mmr_sel_o(msel),
        .core_clk_en_o(cen), .fiq_take_o(ftake), .irq_take_o(itake), .vector_o(vec));
    mmrd_flash_model flash (.re_i(fre), .addr_i(faddr), .rdata_o(frd));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] hw(input logic [14:0] ha);
        return {ha, 1'b1} ^ 16'h5A00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Valid is held up to the edge that samples ready high, then dropped there
    task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] ad,
                        input logic [31:0] wd);
        @(posedge clk);
        req <= '{valid:1'b1, write:wr, size:sz, addr:ad, wdata:wd};
        lat = 0; nre = 0; boot = 0; mmr = 0;
        do begin
            @(posedge clk); #1; lat++;
            if (fre) begin nre++; pg = fpage; boot |= fboot; end
            mmr |= msel;
        end while (rsp.ready !== 1'b1 && lat < 50);
        if (rsp.ready !== 1'b1) errors++;
        rd = rsp.rdata; er = rsp.error;
        @(posedge clk);
        req.valid <= 1'b0;
    endtask
    task automatic remap_set(input logic [7:0] v);
        @(posedge clk); remap_wr <= 1'b1; remap_wd <= v;
        @(posedge clk); remap_wr <= 1'b0;
        @(posedge clk); #1 chk(remap, v[0]);
    endtask
    task automatic int_test(input logic f, input logic n, input logic [31:0] v);
        @(posedge clk); fiq <= f; irq <= n;
        repeat (4) @(posedge clk);
        #1 chk({ftake, itake}, 2'b00);
        @(posedge clk); #1 chk({ftake, itake}, {f, ~f});
        chk(vec, v);
        @(posedge clk); fiq <= 1'b0; irq <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
    // Whole run needs a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin errors++; end_of_test(); end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h0C997DE3; errors = 0; num_checks = 0; cyc = 0;
        rstn = 1'b0; req = '0; remap_wr = 1'b0; remap_wd = 8'h00;
        cdiv = 3'h0; fiq = 1'b0; irq = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        #1 chk(remap, 1'b1);
        xfer(1'b0, 2'h2, 32'h0, 32'h0); chk(rd, {hw(15'h1), hw(15'h0)});
        chk(lat, 3);
        chk(nre, 2);
        for (i = 0; i < 3; i++) begin
            xfer(1'b0, 2'h1, `MMRD_FLASH_BASE + ofs[i], 32'h0);
            chk(rd, {2{hw(ofs[i][15:1])}});
            chk(lat, 2);
            chk(boot, ofs[i] >= 16'hF800);
            chk(pg, ofs[i][15:8]);
        end
        $display("test flash done");
        xfer(1'b1, 2'h2, `MMRD_FLASH_BASE, 32'h1234_5678); chk(er, 1'b1);
        xfer(1'b0, 2'h2, 32'h4000_0000, 32'h0); chk(er, 1'b1);
        xfer(1'b0, 2'h2, `MMRD_SRAM_BASE + 32'h2000, 32'h0); chk(er, 1'b1);
        xfer(1'b0, 2'h2, 32'hFFFF_0100, 32'h0); chk(mmr, 1'b1);
        chk(er, 1'b0);
        chk(rd, 32'h0);
        xfer(1'b0, 2'h2, 32'hFFFF_0200, 32'h0); chk(mmr, 1'b0);
        $display("test decode done");
        xfer(1'b1, 2'h2, `MMRD_SRAM_BASE, 32'h4433_2211);
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, 2'h0, `MMRD_SRAM_BASE + i, 32'h0); chk(rd[8*i+:8], 8'h11 * (i + 1));
        end
        xfer(1'b0, 2'h1, `MMRD_SRAM_BASE + 2, 32'h0); chk(rd[31:16], 16'h4433);
        xfer(1'b1, 2'h0, `MMRD_SRAM_BASE + 1, 32'h0000_EE00);
        xfer(1'b1, 2'h1, `MMRD_SRAM_BASE + 2, 32'hBEEF_0000);
        xfer(1'b0, 2'h2, `MMRD_SRAM_BASE, 32'h0); chk(rd, 32'hBEEF_EE11);
        for (k = 0; k < 8; k++) begin
            w = $random(seed);
            a = `MMRD_SRAM_BASE + 32'h0000_1FFC - ({$random(seed)} % 2048) * 4;
            xfer(1'b1, 2'h2, a, w);
            xfer(1'b0, 2'h2, a, 32'h0); chk(rd, w);
            chk(lat, 1);
        end
        $display("test sram done");
        xfer(1'b1, 2'h2, `MMRD_SRAM_BASE, 32'hCAFE_0001);
        remap_set(8'hFE);
        xfer(1'b0, 2'h2, 32'h0, 32'h0); chk(rd, 32'hCAFE_0001);
        remap_set(8'h01);
        xfer(1'b0, 2'h2, 32'h4, 32'h0); chk(rd, {hw(15'h3), hw(15'h2)});
        $display("test remap done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk); cdiv <= k[2:0];
            repeat (3) @(posedge clk);
            i = 0;
            repeat (16) begin @(posedge clk); #1 i += cen; end
            chk(i, 16 >> k);
        end
        $display("test divider done");
        int_test(1'b1, 1'b1, 32'h0000_001C);
        int_test(1'b0, 1'b1, 32'h0000_0018);
        $display("test interrupt done");
        end_of_test();
    end
endmodule // memory_map_remap_decoder_tb

// ==== sim/mmrd_flash_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Flash array model
// ----------------------------------------
module mmrd_flash_model (
    input  wire logic        re_i,    // Halfword read strobe
    input  wire logic [14:0] addr_i,  // Halfword address
    output logic      [15:0] rdata_o  // Data, valid while the strobe stands
);
    // Data stands only with the strobe; otherwise the inverse shows, so a
    // capture in the wrong cycle is caught
    assign rdata_o = re_i ? ({addr_i, 1'b1} ^ 16'h5A00) : ~({addr_i, 1'b1} ^ 16'h5A00);
endmodule // mmrd_flash_model
